//--- panel_params.svh
// Purpose: constants and register map of the front panel key and mode controller
// Assumes: 20 MHz clock, byte-addressed Avalon-MM slave
// Notes:   offsets are byte addresses, one aligned 32-bit word each
// Contract
// - nine operating modes exist and each mode key press changes the active mode.
// - each mode has a selection display and an execution display, toggled by the set key.
// - only the digit whose decimal point flashes is modified.
// - with no flashing decimal point the up, down and shift keys are ignored; the code lets up and down step monitorFunc on the monitor selection screen.
// - with a flashing point, up and down change the marked digit or step the parameter.
// - with a flashing point, shift moves the edit position to the next higher digit.
// - during step data entry, shift discards the data entered so far.
// - in test run mode, shift starts the selected test run action.
// - during step data entry, up and down load the present coordinate, only after origin return.
// - after power-on the display shows what the initial display parameter selects; reset clears initSel too, so monitorFunc always starts at 0.
// - on a drive trip the display shows the error cause with all digits flashing.
// - while the external console is attached all panel keys are disabled.
// - nonvolatile write mode copies the parameters into nonvolatile memory.
// - monitor mode offers eight display functions.
// - mode key on a monitor selection screen goes to step data edit mode.
`ifndef PANEL_PARAMS_SVH
`define PANEL_PARAMS_SVH

`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_EDIT        8'h08
`define REG_INITSEL     8'h0C
`define REG_EVENT       8'h10

`define CTRL_ACK_BIT    0
`define INITSEL_RESET   3'h0
`define DEBOUNCE_US     10000
`define CLK_MHZ         20
`define DEBOUNCE_CYC    (`DEBOUNCE_US * `CLK_MHZ)
`define DIGITS          6
`define UNMAPPED_DATA   32'h0000_0000

`endif

//--- panel_pkg.sv
// Purpose: types shared by the panel key and mode controller
// Assumes: mode codes follow the mode key ring in gray order
// Notes:   codes outside the ring are illegal and fall back to monitor
package panel_pkg;
    // gray code along the mode key path
    typedef enum logic [3:0] {
        MODE_MONITOR = 4'h0,
        MODE_STEP    = 4'h1,
        MODE_VEL     = 4'h3,
        MODE_NC      = 4'h2,
        MODE_OFFSET  = 4'h6,
        MODE_SERVO   = 4'h7,
        MODE_NVWRITE = 4'h5,
        MODE_TUNE    = 4'h4,
        MODE_TEST    = 4'hC
    } mode_e;

    typedef struct packed {
        logic modeKey;
        logic setKey;
        logic upKey;
        logic downKey;
        logic shiftKey;
    } keys_s;
endpackage

//--- key_if.sv
`timescale 1ns/1ps
// Purpose: carries the debounced one-cycle key press pulses
// Assumes: source and sink share one clock
// Notes:   at most one pulse per physical press
interface key_if;
    import panel_pkg::*;
    keys_s press;
    modport source (output press);
    modport sink   (input press);
endinterface

//--- key_debounce.sv
`timescale 1ns/1ps
`include "panel_params.svh"
// Purpose: synchronise and debounce five panel keys, one pulse per press
// Assumes: keys active high, asynchronous to clk
// Notes:   hold count is a parameter so simulation can shorten it
module key_debounce
    import panel_pkg::*;
#(
    parameter int HOLD = `DEBOUNCE_CYC
)(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [4:0] keysRaw,
    key_if.source           keys
);
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic [4:0]  stable;
    logic [4:0]  next_stable;
    logic [4:0]  pulse;
    logic [31:0] cnt [5];
    logic [31:0] next_cnt [5];

    always_comb
    begin
        next_stable = stable;
        pulse       = 5'h0;
        for (int i = 0; i < 5; i++)
        begin
            next_cnt[i] = 32'h0000_0000;
            if (sync2[i] != stable[i])
            begin
                next_cnt[i] = cnt[i] + 32'h0000_0001;
                if (cnt[i] >= 32'(HOLD - 1))
                begin
                    next_stable[i] = sync2[i];
                    next_cnt[i]    = 32'h0000_0000;
                    pulse[i]       = sync2[i];   // act once per press
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1  <= 5'h0;
            sync2  <= 5'h0;
            stable <= 5'h0;
            for (int i = 0; i < 5; i++)
                cnt[i] <= 32'h0000_0000;
        end
        else
        begin
            sync1  <= keysRaw;
            sync2  <= sync1;
            stable <= next_stable;
            cnt    <= next_cnt;
        end
    end

    assign keys.press = '{modeKey: pulse[4], setKey: pulse[3], upKey: pulse[2],
                          downKey: pulse[1], shiftKey: pulse[0]};
endmodule // key_debounce

//--- front_panel_ctrl.sv
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "panel_params.svh"
// Purpose: front panel mode, display state and digit edit controller
// Assumes: driver core supplies trip, origin, coordinate and console status
// Notes:   actions leave as one-cycle pulses; nv write and test run also set the event register
module front_panel_ctrl
    import panel_pkg::*;
#(
    parameter int DEBOUNCE = `DEBOUNCE_CYC
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  keysRaw,
    input  wire logic        tripRaw,
    input  wire logic        consoleRaw,
    input  wire logic        originDoneRaw,
    input  wire logic [23:0] presentCoord,
    input  wire logic [7:0]  errorCause,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [3:0]  modeCode,
    output logic             execDisplay,
    output logic      [2:0]  monitorFunc,
    output logic      [23:0] editValue,
    output logic      [5:0]  pointFlash,
    output logic             allFlash,
    output logic      [7:0]  shownError,
    output logic             nvWriteStart,
    output logic             testRunStart,
    output logic             tuneStart
);
    key_if keys ();

    key_debounce #(.HOLD(DEBOUNCE)) u_deb (
        .clk     (clk),
        .rst_n   (rst_n),
        .keysRaw (keysRaw),
        .keys    (keys.source)
    );

    logic [2:0] s1;
    logic [2:0] s2;
    logic       trip;
    logic       console;
    logic       originDone;
    assign trip       = s2[2];
    assign console    = s2[1];
    assign originDone = s2[0];

    mode_e       mode;
    mode_e       next_mode;
    logic        next_execDisplay;
    logic [2:0]  next_monitorFunc;
    logic [23:0] next_editValue;
    logic [2:0]  digit;
    logic [2:0]  next_digit;
    logic [2:0]  initSel;
    logic [2:0]  next_initSel;
    logic [2:0]  events;
    logic [2:0]  next_events;
    logic        started;
    logic        next_started;
    logic        next_nv;
    logic        next_test;
    logic        next_tune;
    logic        editing;
    logic [2:0]  setEv;
    logic        wrTake;
    keys_s       k;

    function automatic mode_e nextModeOf(mode_e m);
        unique case (m)
            MODE_MONITOR: nextModeOf = MODE_STEP;
            MODE_STEP:    nextModeOf = MODE_VEL;
            MODE_VEL:     nextModeOf = MODE_NC;
            MODE_NC:      nextModeOf = MODE_OFFSET;
            MODE_OFFSET:  nextModeOf = MODE_SERVO;
            MODE_SERVO:   nextModeOf = MODE_NVWRITE;
            MODE_NVWRITE: nextModeOf = MODE_TUNE;
            MODE_TUNE:    nextModeOf = MODE_TEST;
            MODE_TEST:    nextModeOf = MODE_MONITOR;
            default:      nextModeOf = MODE_MONITOR;
        endcase
    endfunction

    // bcd nibble step with wrap inside one decimal digit
    function automatic logic [23:0] stepDigit(logic [23:0] v, logic [2:0] d, logic up);
        logic [3:0] n;
        logic [23:0] r;
        n = v[d*4 +: 4];
        if (up)
            n = (n >= 4'h9) ? 4'h0 : n + 4'h1;
        else
            n = (n == 4'h0) ? 4'h9 : n - 4'h1;
        r = v;
        r[d*4 +: 4] = n;
        stepDigit = r;
    endfunction

    // one decode for every register write, taken on the answering edge only
    function automatic logic regWrite(logic take, logic [7:0] a, logic [7:0] target);
        regWrite = take && (a == target);
    endfunction

    // console attached freezes every key
    assign k = console ? keys_s'(5'h0) : keys.press;
    // flashing point exists only in execution display of edit modes
    assign editing = execDisplay && mode != MODE_MONITOR && mode != MODE_NVWRITE
                     && mode != MODE_TUNE;

    always_comb
    begin
        next_mode        = mode;
        next_execDisplay = execDisplay;
        next_monitorFunc = monitorFunc;
        next_editValue   = editValue;
        next_digit       = digit;
        next_initSel     = initSel;
        next_started     = 1'b1;
        next_nv          = 1'b0;
        next_test        = 1'b0;
        next_tune        = 1'b0;
        if (!started)
        begin
            next_mode        = MODE_MONITOR;
            next_monitorFunc = initSel;
            next_execDisplay = 1'b1;
        end
        else if (k.modeKey)
        begin
            // monitor selection screen leads to step edit, as does the ring
            next_mode        = nextModeOf(mode);
            next_execDisplay = 1'b0;
            next_digit       = 3'h0;
        end
        else if (k.setKey)
        begin
            next_execDisplay = !execDisplay;
            next_digit       = 3'h0;
            if (!execDisplay && mode == MODE_NVWRITE)
                next_nv = 1'b1;
            if (!execDisplay && mode == MODE_TUNE)
                next_tune = 1'b1;
        end
        else if (mode == MODE_MONITOR && !execDisplay && (k.upKey || k.downKey))
        begin
            // eight monitor functions, wrap both ways
            next_monitorFunc = k.upKey ? monitorFunc + 3'h1 : monitorFunc - 3'h1;
        end
        else if (editing)   // keys dead without a flashing point
        begin
            if (mode == MODE_STEP && (k.upKey || k.downKey))
            begin
                if (originDone)
                    next_editValue = presentCoord;   // teaching
            end
            else if (k.upKey || k.downKey)
                next_editValue = stepDigit(editValue, digit, k.upKey);
            else if (k.shiftKey)
            begin
                if (mode == MODE_STEP)
                    next_editValue = 24'h00_0000;
                else if (mode == MODE_TEST)
                    next_test = 1'b1;
                else
                    next_digit = (digit == 3'(`DIGITS - 1)) ? 3'h0 : digit + 3'h1;
            end
        end
        if (regWrite(wrTake, avs_address, `REG_INITSEL))
            next_initSel = avs_writedata[2:0];
        if (regWrite(wrTake, avs_address, `REG_EDIT))
            next_editValue = avs_writedata[23:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1           <= 3'h0;
            s2           <= 3'h0;
            mode         <= MODE_MONITOR;
            execDisplay  <= 1'b0;
            monitorFunc  <= 3'h0;
            editValue    <= 24'h00_0000;
            digit        <= 3'h0;
            initSel      <= `INITSEL_RESET;
            started      <= 1'b0;
            nvWriteStart <= 1'b0;
            testRunStart <= 1'b0;
            tuneStart    <= 1'b0;
        end
        else
        begin
            s1           <= {tripRaw, consoleRaw, originDoneRaw};
            s2           <= s1;
            mode         <= next_mode;
            execDisplay  <= next_execDisplay;
            monitorFunc  <= next_monitorFunc;
            editValue    <= next_editValue;
            digit        <= next_digit;
            initSel      <= next_initSel;
            started      <= next_started;
            nvWriteStart <= next_nv;
            testRunStart <= next_test;
            tuneStart    <= next_tune;
        end
    end

    assign modeCode   = mode;
    // trip overrides every mode screen
    assign allFlash   = trip;
    assign shownError = trip ? errorCause : 8'h00;
    assign pointFlash = trip ? 6'h3F : (editing ? 6'(1 << digit) : 6'h00);

    // one wait state: answer registered on the second cycle
    logic pending;
    logic next_pending;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    always_comb
    begin
        next_pending = (avs_read || avs_write) && !pending;
        next_rdata   = rdata;
        if (avs_read && !pending)
        begin
            unique case (avs_address)
                `REG_CTRL:    next_rdata = {31'h0000_0000, console};
                `REG_STATUS:  next_rdata = {19'h0_0000, monitorFunc, allFlash, originDone,
                                            execDisplay, digit, mode};
                `REG_EDIT:    next_rdata = {8'h00, editValue};
                `REG_INITSEL: next_rdata = {29'h0000_0000, initSel};
                `REG_EVENT:   next_rdata = {29'h0000_0000, events};
                default:      next_rdata = `UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pending <= 1'b0;
            rdata   <= 32'h0000_0000;
        end
        else
        begin
            pending <= next_pending;
            rdata   <= next_rdata;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !pending;
    assign avs_readdata    = rdata;
    // a write lands only on the edge that sees waitrequest low
    assign wrTake          = avs_write && pending;

    // event flags; a hardware set wins over a software clear in the same cycle
    always_comb
    begin
        setEv       = {trip, next_test, next_nv};
        next_events = events;
        if (regWrite(wrTake, avs_address, `REG_EVENT))
            next_events = events & ~avs_writedata[2:0];
        next_events = next_events | setEv;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            events <= 3'h0;
        else
            events <= next_events;
    end
endmodule // front_panel_ctrl

//--- front_panel_assertions.sv
`timescale 1ns/1ps
// Purpose: port-level checks of the panel mode and edit controller
// Assumes: single clock, synchronous active-low reset
// Notes:   bus writes and step teaching may rewrite every digit
module front_panel_assertions
    import panel_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        consoleRaw,
    input wire logic [7:0]  errorCause,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [3:0]  modeCode,
    input wire logic        execDisplay,
    input wire logic [23:0] editValue,
    input wire logic [5:0]  pointFlash,
    input wire logic        allFlash,
    input wire logic [7:0]  shownError,
    input wire logic        nvWriteStart,
    input wire logic        testRunStart
);
    logic [23:0] mask;
    always_comb
        for (int i = 0; i < 24; i++) mask[i] = pointFlash[i / 4];
    function automatic logic [3:0] nextMode(input logic [3:0] m);
        case (m)
            MODE_MONITOR: return MODE_STEP;
            MODE_STEP:    return MODE_VEL;
            MODE_VEL:     return MODE_NC;
            MODE_NC:      return MODE_OFFSET;
            MODE_OFFSET:  return MODE_SERVO;
            MODE_SERVO:   return MODE_NVWRITE;
            MODE_NVWRITE: return MODE_TUNE;
            MODE_TUNE:    return MODE_TEST;
            default:      return MODE_MONITOR;
        endcase
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_mode_ring: assert property ($past(rst_n) && $changed(modeCode) |->
        modeCode == nextMode($past(modeCode))) else $error("mode step out of order");
    a_console_lock: assert property (consoleRaw [*4] |=>
        $stable(modeCode) && $stable(execDisplay)) else $error("key acted with console on");
    a_trip_flash: assert property (allFlash |-> pointFlash == 6'h3F)
        else $error("trip without all digits flashing");
    a_trip_error: assert property (allFlash |-> shownError == errorCause)
        else $error("trip cause not shown");
    a_error_idle: assert property (!allFlash |-> shownError == 8'h00)
        else $error("error shown without trip");
    a_one_digit: assert property (!allFlash |-> $onehot0(pointFlash))
        else $error("more than one digit marked");
    a_select_quiet: assert property (!execDisplay && !allFlash |-> pointFlash == 6'h00)
        else $error("flashing point on selection display");
    a_digit_only: assert property ($past(rst_n) && !$past(avs_write)
        && $past(modeCode) != MODE_STEP |-> ((editValue ^ $past(editValue)) & ~$past(mask))
        == 24'h00_0000) else $error("unmarked digit changed");
    a_test_start: assert property (testRunStart |-> modeCode == MODE_TEST && execDisplay)
        else $error("test run started outside test mode");
    a_nv_start: assert property (nvWriteStart |-> modeCode == MODE_NVWRITE && execDisplay)
        else $error("store started outside store mode");
    a_bus_wait: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer not in second cycle");
    c_test: cover property (testRunStart);
    c_store: cover property (nvWriteStart);
    c_trip: cover property (allFlash);
endmodule // front_panel_assertions

bind front_panel_ctrl front_panel_assertions i_chk (.clk, .rst_n, .consoleRaw, .errorCause,
    .avs_read, .avs_write, .avs_waitrequest, .modeCode, .execDisplay, .editValue,
    .pointFlash, .allFlash, .shownError, .nvWriteStart, .testRunStart);

//--- panel_operator.sv
`timescale 1ns/1ps
// Purpose: operator at the panel, one key held then fully released
// Assumes: next request only once busy has dropped
// Notes:   release as long as the hold so debounce sees it open
module panel_operator #(
    parameter int HOLD = 10
)(
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [4:0] key,
    output logic      [4:0] keysRaw,
    output logic            busy
);
    logic [4:0] held = 5'h00;
    int         cnt  = 0;
    always_ff @(posedge clk)
    begin
        if (go)
            held <= key;
        cnt <= go ? 2 * HOLD : (cnt > 0 ? cnt - 1 : 0);
    end
    assign keysRaw = (cnt > HOLD) ? held : 5'h00;
    assign busy    = go || (cnt != 0);
endmodule // panel_operator

//--- tb.sv
`timescale 1ns/1ps
// Purpose: scenario bench of the panel mode and edit controller
// Assumes: debounce shortened to 4 cycles
// Notes:   pulses are caught in sticky flags
module tb;
    import panel_pkg::*;
    localparam int K_MODE = 4, K_SET = 3, K_UP = 2, K_DN = 1, K_SH = 0;
    logic        clk = 0, rst_n = 0, go = 0, tripRaw = 0, consoleRaw = 0, originDoneRaw = 0;
    logic        avs_read = 0, avs_write = 0, avs_waitrequest, busy, execDisplay, allFlash;
    logic        nvWriteStart, testRunStart, tuneStart, sawNv = 0, sawTest = 0, sawTune = 0;
    logic [4:0]  key = 5'h00, keysRaw;
    logic [7:0]  avs_address = 8'h00, errorCause = 8'h00, shownError;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
    logic [23:0] presentCoord = 24'h00_0000, editValue;
    logic [3:0]  modeCode;
    logic [2:0]  monitorFunc;
    logic [5:0]  pointFlash;
    int          nErrors = 0, checked = 0, cyc = 0;
    mode_e       ring [9] = '{MODE_MONITOR, MODE_STEP, MODE_VEL, MODE_NC, MODE_OFFSET,
                              MODE_SERVO, MODE_NVWRITE, MODE_TUNE, MODE_TEST};
    front_panel_ctrl #(.DEBOUNCE(4)) i_dut (.clk, .rst_n, .keysRaw, .tripRaw, .consoleRaw,
        .originDoneRaw, .presentCoord, .errorCause, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .modeCode, .execDisplay,
        .monitorFunc, .editValue, .pointFlash, .allFlash, .shownError, .nvWriteStart,
        .testRunStart, .tuneStart);
    panel_operator i_op (.clk, .go, .key, .keysRaw, .busy);
    initial
        forever #25 clk = ~clk;
    task automatic close_out;
        if (nErrors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (testRunStart === 1'b1) sawTest <= 1;
        if (nvWriteStart === 1'b1) sawNv <= 1;
        if (tuneStart === 1'b1) sawTune <= 1;
        if (cyc == 20000)
        begin
            nErrors++;
            close_out;
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            nErrors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic press(input int b);
        @(posedge clk);
        key <= 5'(1 << b);
        go <= 1;
        @(posedge clk);
        go <= 0;
        do @(negedge clk); while (busy);
        repeat (4) @(negedge clk);
    endtask
    task automatic goto(input mode_e m, input logic e);
        for (int i = 0; i < 9 && modeCode !== m; i++) press(K_MODE);
        if (execDisplay !== e) press(K_SET);
    endtask
    task automatic t_reset;
        logic [31:0] q;
        chk(modeCode, MODE_MONITOR);
        chk(monitorFunc, 3'h0);
        bus(0, 8'h0C, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        bus(0, 8'h40, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
    endtask
    task automatic t_ring;
        goto(MODE_MONITOR, 0);
        chk(execDisplay, 1'b0);
        press(K_UP);
        chk(monitorFunc, 3'h1);
        press(K_DN);
        press(K_DN);
        chk(monitorFunc, 3'h7);
        for (int i = 1; i <= 9; i++)
        begin
            press(K_MODE);
            chk(modeCode, ring[i % 9]);
        end
    endtask
    task automatic t_edit;
        logic [31:0] q;
        logic [23:0] v;
        int          d;
        int          e;
        goto(MODE_VEL, 1);
        bus(1, 8'h08, 32'h0000_0000, q);
        bus(0, 8'h04, 32'h0000_0000, q);
        d = 0;
        e = 1;
        chk(q[7:0], {1'b1, 3'h0, MODE_VEL});
        chk(pointFlash, 6'(1 << d));
        press(K_UP);
        chk(editValue, 24'(1 << (4 * d)));
        press(K_SH);
        chk(pointFlash, 6'(1 << e));
        press(K_DN);
        v = 24'(1 << (4 * d)) | 24'(9 << (4 * e));
        chk(editValue, v);
        press(K_SET);
        chk(pointFlash, 6'h00);
        press(K_UP);
        press(K_SH);
        chk(editValue, v);
    endtask
    task automatic t_step;
        logic [31:0] q;
        goto(MODE_STEP, 1);
        @(posedge clk);
        presentCoord <= 24'h12_3456;
        bus(1, 8'h08, 32'h0000_0011, q);
        press(K_UP);
        chk(editValue, 24'h00_0011);
        @(posedge clk);
        originDoneRaw <= 1;
        press(K_DN);
        chk(editValue, 24'h12_3456);
        press(K_SH);
        chk(editValue, 24'h00_0000);
    endtask
    task automatic t_start;
        logic [31:0] q;
        goto(MODE_NVWRITE, 0);
        sawNv <= 0;
        press(K_SET);
        chk(sawNv, 1'b1);
        goto(MODE_TUNE, 0);
        sawTune <= 0;
        press(K_SET);
        chk(sawTune, 1'b1);
        goto(MODE_TEST, 1);
        sawTest <= 0;
        press(K_SH);
        chk(sawTest, 1'b1);
        bus(0, 8'h10, 32'h0000_0000, q);
        chk(q, 32'h0000_0003);
        bus(1, 8'h10, 32'h0000_0007, q);
    endtask
    task automatic t_trip;
        logic [31:0] q;
        @(posedge clk);
        tripRaw <= 1;
        errorCause <= 8'h57;
        repeat (4) @(negedge clk);
        chk(allFlash, 1'b1);
        chk(pointFlash, 6'h3F);
        chk(shownError, 8'h57);
        @(posedge clk);
        tripRaw <= 0;
        repeat (4) @(negedge clk);
        bus(0, 8'h10, 32'h0000_0000, q);
        chk(q, 32'h0000_0004);
    endtask
    task automatic t_console;
        logic [3:0]  m;
        logic [31:0] q;
        @(posedge clk);
        consoleRaw <= 1;
        repeat (4) @(negedge clk);
        m = modeCode;
        press(K_MODE);
        chk(modeCode, m);
        bus(0, 8'h00, 32'h0000_0000, q);
        chk(q, 32'h0000_0001);
        @(posedge clk);
        consoleRaw <= 0;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(negedge clk);
        t_reset;
        t_ring;
        t_edit;
        t_step;
        t_start;
        t_trip;
        t_console;
        close_out;
    end
endmodule // tb
